/* core/eia_pkg.sv */
// Package: opcodes, widths, field positions and carriers for the decoder
`default_nettype none
package eia_pkg;
  localparam int EIA_IW = 16;
  localparam int EIA_PW = 12;
  localparam int EIA_AW = 12;
  localparam int EIA_FW = 8;
  localparam int EIA_BW = 4;
  localparam int EIA_LITW = 6;
  localparam logic [7:0] EIA_SUBF_OP = 8'hE9;
  localparam logic [1:0] EIA_SEL_FRAME = 2'h3;
  localparam logic [7:0] EIA_IDX_MAX = 8'h5F;
  localparam logic [3:0] EIA_ACC_HI_BANK = 4'hF;
  localparam int EIA_OP_HI = 15;
  localparam int EIA_OP_LO = 8;
  localparam int EIA_SEL_HI = 7;
  localparam int EIA_SEL_LO = 6;
  localparam int EIA_A_BIT = 8;
  localparam int EIA_D_BIT = 9;
  localparam logic [EIA_AW-1:0] EIA_FRAME_RST = 12'h000;

  typedef struct packed {
    logic [EIA_AW-1:0] addr;
    logic indexed;
    logic toWreg;
    logic valid;
  } eia_daddr_t;

  typedef struct packed {
    logic load;
    logic [EIA_PW-1:0] target;
    logic pop;
    logic flush;
  } eia_ret_t;
endpackage
`default_nettype wire

/* core/eia_frame_reg.sv */
// Stack-frame pointer storage with subtract port
`timescale 1ns/1ps
`default_nettype none
module eia_frame_reg
  import eia_pkg::*;
#(
  parameter int AW = EIA_AW
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic subEn,
  input wire logic [EIA_LITW-1:0] subLit,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrData,
  output logic [AW-1:0] frameReg
);
  // Full-width subtract, no status flags touched
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      frameReg <= AW'(EIA_FRAME_RST);
    end else if (subEn) begin
      frameReg <= frameReg - AW'(subLit);
    end else if (wrEn) begin
      frameReg <= wrData;
    end
  end
endmodule // eia_frame_reg
`default_nettype wire

/* core/eia_decode.sv */
// Extended-mode decoder: subtract-and-return and indexed operand addressing
// Notes on behaviour
// - Subtract-and-return takes unsigned 6-bit literal off the frame pointer.
// - Then it returns: program counter loads popped return stack top.
// - One word, two cycles; second cycle is a no-operation.
// - Subtract-from-pointer opcode with select 11 is subtract-and-return.
// - Extended off: file address literal, access bank or bank select.
// - Extended on, access 0, address up to 5Fh: offset from pointer.
// - Addresses above 5Fh keep literal meaning even when extended.
// - Offset mode covers all byte and bit instructions with access bit.
// - One enable turns on both new opcodes and offset addressing.
// - Pointer zero gives the ordinary lower access-bank addresses.
// - Destination bit keeps choosing working register or memory.
// - Indexed address is frame pointer plus instruction literal.
`timescale 1ns/1ps
`default_nettype none
module eia_decode
  import eia_pkg::*;
#(
  parameter int AW = EIA_AW,
  parameter int PW = EIA_PW
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic extEnable,
  input wire logic instrValid,
  input wire logic [EIA_IW-1:0] instrWord,
  input wire logic byteBitOp,
  input wire logic [EIA_BW-1:0] bankSelect,
  input wire logic [PW-1:0] returnStackTop,
  input wire logic frameWrEn,
  input wire logic [AW-1:0] frameWrData,
  output var eia_daddr_t dataAddr,
  output var eia_ret_t retCtl,
  output logic [AW-1:0] stackFramePointer,
  output logic execStall
);
  typedef enum logic [0:0] {EIA_RUN, EIA_NOP2} eia_state_t;

  eia_state_t stateReg;
  eia_state_t stateNext;
  logic isSubRet;
  logic indexedHit;
  logic [AW-1:0] addrNext;
  logic [AW-1:0] framePtr;

  // Opcode match for pointer subtract with frame select
  function automatic logic subRetMatch(input logic [EIA_IW-1:0] w);
    return (w[EIA_OP_HI:EIA_OP_LO] == EIA_SUBF_OP) &&
      (w[EIA_SEL_HI:EIA_SEL_LO] == EIA_SEL_FRAME);
  endfunction

  // Offset form only for low access-bank operands
  function automatic logic idxMatch(input logic [EIA_IW-1:0] w,
                                    input logic en);
    return en && !w[EIA_A_BIT] &&
      (w[EIA_FW-1:0] <= EIA_IDX_MAX);
  endfunction

  // New opcode only decoded while extension is on; during the nop cycle
  // the fetched word is the stale prefetch and must be ignored
  assign isSubRet = instrValid && extEnable && (stateReg == EIA_RUN) &&
    subRetMatch(instrWord);

  assign indexedHit = byteBitOp && idxMatch(instrWord, extEnable);

  eia_frame_reg #(
    .AW(AW)
  ) u_frame (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .subEn(isSubRet),
    .subLit(instrWord[EIA_LITW-1:0]),
    .wrEn(frameWrEn),
    .wrData(frameWrData),
    .frameReg(framePtr)
  );

  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      EIA_RUN: begin
        if (isSubRet) begin
          stateNext = EIA_NOP2;
        end
      end
      EIA_NOP2: begin
        stateNext = EIA_RUN;
      end
      default: begin
        stateNext = EIA_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stateReg <= EIA_RUN;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Address formation; pointer zero naturally maps offset to itself
  always_comb begin
    if (indexedHit) begin
      addrNext = framePtr + AW'(instrWord[EIA_FW-1:0]);
    end else if (!instrWord[EIA_A_BIT]) begin
      if (instrWord[EIA_FW-1:0] <= EIA_IDX_MAX) begin
        addrNext = AW'(instrWord[EIA_FW-1:0]);
      end else begin
        addrNext = AW'({EIA_ACC_HI_BANK, instrWord[EIA_FW-1:0]});
      end
    end else begin
      addrNext = AW'({bankSelect, instrWord[EIA_FW-1:0]});
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dataAddr <= '0;
    end else begin
      dataAddr.valid <= instrValid && byteBitOp && (stateReg == EIA_RUN);
      dataAddr.addr <= addrNext;
      dataAddr.indexed <= indexedHit;
      dataAddr.toWreg <= !instrWord[EIA_D_BIT];
    end
  end

  // Return issued with pointer update; flush covers the nop cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      retCtl <= '0;
    end else begin
      retCtl.load <= isSubRet;
      retCtl.pop <= isSubRet;
      retCtl.target <= returnStackTop;
      retCtl.flush <= isSubRet;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      execStall <= 1'b0;
    end else begin
      execStall <= (stateNext == EIA_NOP2);
    end
  end

  // Pointer output registered for the datapath
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stackFramePointer <= AW'(EIA_FRAME_RST);
    end else begin
      stackFramePointer <= framePtr;
    end
  end

  sequence s_subret_issue;
    isSubRet;
  endsequence

  sequence s_nop_cycle;
    (stateReg == EIA_NOP2) ##1 (stateReg == EIA_RUN);
  endsequence

  a_subret_two_cycles: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_subret_issue |=> s_nop_cycle)
    else $error("subtract-and-return not two cycles");

  a_pointer_subtract: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    isSubRet && !frameWrEn |=>
      framePtr == $past(framePtr) - AW'($past(instrWord[EIA_LITW-1:0])))
    else $error("frame pointer not reduced by literal");

  a_return_load: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    isSubRet |=> retCtl.load && retCtl.pop &&
      retCtl.target == $past(returnStackTop))
    else $error("return not issued with stack top");

  a_nop_no_decode: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (stateReg == EIA_NOP2) |-> !isSubRet ##1 !dataAddr.valid)
    else $error("prefetched word executed in nop cycle");

  a_indexed_addr: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    indexedHit |=>
      dataAddr.addr == $past(framePtr) + AW'($past(instrWord[EIA_FW-1:0])))
    else $error("indexed address not pointer plus offset");

  a_high_literal: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrWord[EIA_FW-1:0] > EIA_IDX_MAX |-> !indexedHit)
    else $error("high address taken as offset");

  a_ext_off_literal: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !extEnable && instrWord[EIA_A_BIT] |=>
      dataAddr.addr == {$past(bankSelect), $past(instrWord[EIA_FW-1:0])})
    else $error("banked address wrong in standard mode");

  a_dest_select: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> dataAddr.toWreg == !$past(instrWord[EIA_D_BIT]))
    else $error("destination bit meaning changed");

  a_ext_gate: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !extEnable |-> !isSubRet && !indexedHit)
    else $error("extension active while disabled");

  // Return controls leave together as one-cycle pulses
  sequence s_ret_pulse;
    retCtl.load && retCtl.pop && retCtl.flush;
  endsequence

  sequence s_ret_quiet;
    !retCtl.load && !retCtl.pop && !retCtl.flush;
  endsequence

  a_ret_pulse_once: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_subret_issue |=> s_ret_pulse ##1 s_ret_quiet)
    else $error("return controls not a single pulse");

  a_flush_stall: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    isSubRet |=> retCtl.flush && execStall)
    else $error("prefetch not flushed with stall");

  a_stall_single: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    execStall |=> !execStall)
    else $error("stall longer than one cycle");

  a_stall_source: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    execStall |-> $past(isSubRet))
    else $error("stall without subtract-and-return");

  a_load_source: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    retCtl.load |-> $past(isSubRet))
    else $error("return issued without subtract-and-return");

  a_pointer_shadow: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> stackFramePointer == $past(framePtr))
    else $error("pointer output not following pointer");

  a_frame_load: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !isSubRet && frameWrEn |=> framePtr == $past(frameWrData))
    else $error("datapath pointer write lost");

  // Only the subtract or a datapath write may move the pointer
  a_pointer_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !isSubRet && !frameWrEn |=> $stable(framePtr))
    else $error("pointer changed without cause");

  a_subret_decode: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && extEnable && (stateReg == EIA_RUN) &&
      (instrWord[EIA_OP_HI:EIA_OP_LO] == EIA_SUBF_OP) &&
      (instrWord[EIA_SEL_HI:EIA_SEL_LO] == EIA_SEL_FRAME) |-> isSubRet)
    else $error("subtract-and-return opcode missed");

  a_other_select: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrWord[EIA_SEL_HI:EIA_SEL_LO] != EIA_SEL_FRAME |-> !isSubRet)
    else $error("return taken for other pointer select");

  a_index_window: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    byteBitOp && extEnable && !instrWord[EIA_A_BIT] &&
      (instrWord[EIA_FW-1:0] <= EIA_IDX_MAX) |-> indexedHit)
    else $error("low access operand not indexed");

  a_zero_pointer: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    indexedHit && (framePtr == '0) |=>
      dataAddr.addr == AW'($past(instrWord[EIA_FW-1:0])))
    else $error("zero pointer does not map offset to itself");

  a_access_low: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !extEnable && !instrWord[EIA_A_BIT] &&
      (instrWord[EIA_FW-1:0] <= EIA_IDX_MAX) |=>
      dataAddr.addr == AW'($past(instrWord[EIA_FW-1:0])))
    else $error("lower access bank address wrong");

  a_access_high: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !instrWord[EIA_A_BIT] && (instrWord[EIA_FW-1:0] > EIA_IDX_MAX) |=>
      dataAddr.addr == {EIA_ACC_HI_BANK, $past(instrWord[EIA_FW-1:0])})
    else $error("upper access bank address wrong");

  // Banked operands are never reinterpreted, extension or not
  a_banked_ext: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrWord[EIA_A_BIT] |=>
      dataAddr.addr == {$past(bankSelect), $past(instrWord[EIA_FW-1:0])})
    else $error("banked operand reinterpreted");

  a_valid_gate: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    dataAddr.valid |-> $past(instrValid) && $past(byteBitOp))
    else $error("address valid without byte or bit op");
endmodule // eia_decode
`default_nettype wire

/* verification/eia_rstk_model.sv */
// Return stack model feeding the decoder's return path
`timescale 1ns/1ps
`default_nettype none
module eia_rstk_model
  import eia_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire eia_ret_t retCtl,
  output logic [EIA_PW-1:0] returnStackTop
);
  logic [1:0] popCnt_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) popCnt_reg <= 2'h0;
    else if (retCtl.pop) popCnt_reg <= popCnt_reg + 2'h1;
  end
  // Distinct address for each of four pops, then wraps, so a stale top cannot pass
  assign returnStackTop = {8'h1A, 2'h0, popCnt_reg};
endmodule // eia_rstk_model
`default_nettype wire

/* verification/eia_decode_tb.sv */
// Self-checking bench for the extended-mode decoder
`timescale 1ns/1ps
`default_nettype none
module eia_decode_tb;
  import eia_pkg::*;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic extEnable = 1'h0;
  logic instrValid = 1'h0;
  logic byteBitOp = 1'h0;
  logic frameWrEn = 1'h0;
  logic [EIA_IW-1:0] instrWord = '0;
  logic [EIA_BW-1:0] bankSelect = 4'h5;
  logic [EIA_AW-1:0] frameWrData = '0;
  logic [EIA_PW-1:0] returnStackTop;
  eia_daddr_t dataAddr;
  eia_ret_t retCtl;
  logic [EIA_AW-1:0] stackFramePointer;
  logic execStall;
  int errors = 0;
  int checks = 0;
  eia_decode dut (.sys_clk(sys_clk), .rst_n(rst_n), .extEnable(extEnable),
    .instrValid(instrValid), .instrWord(instrWord), .byteBitOp(byteBitOp),
    .bankSelect(bankSelect), .returnStackTop(returnStackTop),
    .frameWrEn(frameWrEn), .frameWrData(frameWrData), .dataAddr(dataAddr),
    .retCtl(retCtl), .stackFramePointer(stackFramePointer),
    .execStall(execStall));
  eia_rstk_model part (.sys_clk(sys_clk), .rst_n(rst_n), .retCtl(retCtl),
    .returnStackTop(returnStackTop));
  initial forever #12.5 sys_clk = ~sys_clk;
  task tick;
    @(posedge sys_clk);
    #1;
  endtask
  task chk12(input logic [11:0] g, input logic [11:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task setptr(input logic [11:0] v);
    frameWrEn = 1'h1;
    frameWrData = v;
    tick;
    frameWrEn = 1'h0;
    tick;
  endtask
  // One decoded byte/bit op, then an idle cycle before the next
  task op(input logic [15:0] w, input logic [11:0] ea, input logic ix,
          input logic tw);
    instrWord = w;
    byteBitOp = 1'h1;
    instrValid = 1'h1;
    tick;
    instrValid = 1'h0;
    chk1(dataAddr.valid, 1'h1);
    chk12(dataAddr.addr, ea);
    chk1(dataAddr.indexed, ix);
    chk1(dataAddr.toWreg, tw);
    tick;
  endtask
  task t_literal;
    setptr(12'h300);
    extEnable = 1'h0;
    op({6'h09, 2'h2, 8'h20}, 12'h020, 1'h0, 1'h0);
    op({6'h09, 2'h0, 8'h80}, 12'hF80, 1'h0, 1'h1);
    op({6'h09, 2'h3, 8'h20}, 12'h520, 1'h0, 1'h0);
  endtask
  task t_indexed;
    extEnable = 1'h1;
    op({6'h09, 2'h2, 8'h5F}, 12'h35F, 1'h1, 1'h0);
    op({6'h09, 2'h0, 8'h60}, 12'hF60, 1'h0, 1'h1);
    op({6'h09, 2'h1, 8'h10}, 12'h510, 1'h0, 1'h1);
    op(16'h8A05, 12'h305, 1'h1, 1'h0);
    setptr(12'h000);
    op({6'h09, 2'h0, 8'h20}, 12'h020, 1'h1, 1'h1);
  endtask
  // Word offered in the stall cycle must be dropped
  task sub_ret(input logic [11:0] p, input logic [15:0] w,
               input logic [11:0] et, input logic [11:0] ep);
    setptr(p);
    extEnable = 1'h1;
    instrWord = w;
    byteBitOp = 1'h0;
    instrValid = 1'h1;
    tick;
    chk1(retCtl.load & retCtl.pop, 1'h1);
    chk1(retCtl.flush, 1'h1);
    chk12(retCtl.target, et);
    chk1(execStall, 1'h1);
    instrWord = {6'h09, 2'h0, 8'h20};
    byteBitOp = 1'h1;
    tick;
    instrValid = 1'h0;
    chk1(dataAddr.valid, 1'h0);
    chk1(execStall | retCtl.load, 1'h0);
    chk12(stackFramePointer, ep);
    tick;
  endtask
  task no_ret(input logic en, input logic [15:0] w);
    setptr(12'h100);
    extEnable = en;
    instrWord = w;
    byteBitOp = 1'h0;
    instrValid = 1'h1;
    tick;
    instrValid = 1'h0;
    chk1(retCtl.load | execStall, 1'h0);
    tick;
    chk12(stackFramePointer, 12'h100);
  endtask
  task tally_and_finish;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    rst_n = 1'h1;
    t_literal;
    t_indexed;
    sub_ret(12'h3FF, 16'hE9E3, 12'h1A0, 12'h3DC);
    sub_ret(12'h010, 16'hE9FF, 12'h1A1, 12'hFD1);
    no_ret(1'h0, 16'hE9C5);
    no_ret(1'h1, 16'hE905);
    tally_and_finish;
  end
endmodule // eia_decode_tb
`default_nettype wire
